// ===== rtl/sorl_disc_timer.sv
// Discrepancy timer: measures how long the two safety inputs disagree
// Assumes synchronised inputs on the core clock
`timescale 1ns/1ps
module sorl_disc_timer #(
  parameter int unsigned LIMIT = 10000000
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic enable_in,
  input wire logic safe_a_in,
  input wire logic safe_b_in,
  output logic expired_out
);
  // One spare count so that the pulse marks the cycle after the limit
  localparam int W = $clog2(LIMIT + 2);
  initial
  begin
    if (LIMIT < 1)
      $error("sorl_disc_timer LIMIT must be at least one");
  end
  logic [W-1:0] cnt_reg, cnt_next;
  logic exp_reg, exp_next;

  // Count while inputs differ; exceeding the limit gives a one-cycle pulse
  always_comb
  begin
    cnt_next = '0;
    exp_next = 1'b0;
    if (enable_in && (safe_a_in != safe_b_in))
    begin
      if (cnt_reg == W'(LIMIT + 1))
        cnt_next = cnt_reg;
      else
        cnt_next = cnt_reg + W'(1);
      exp_next = (cnt_reg == W'(LIMIT)); // Strictly more than limit
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired_out = exp_reg;
endmodule

// ===== rtl/sorl_in_sync.sv
// Two-stage synchronisers and edge detectors for the pin inputs
// Assumes pin levels are asynchronous to the core clock
`timescale 1ns/1ps
module sorl_in_sync #(
  parameter int unsigned N = 5
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [N-1:0] pins_in,
  sorl_sync_if.src sync
);
  initial
  begin
    if (N != 5)
      $error("sorl_in_sync expects five inputs");
  end
  logic [N-1:0] s1_reg, s1_next;
  logic [N-1:0] s2_reg, s2_next;
  logic [N-1:0] s3_reg, s3_next;

  // Stage one feeds stage two only; edges come from stages two and three
  always_comb
  begin
    s1_next = pins_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // Bit order: 0 feedback, 1 input a, 2 input b, 3 reset button, 4 ack button
  assign sync.feedback = s2_reg[0];
  assign sync.safe_a = s2_reg[1];
  assign sync.safe_b = s2_reg[2];
  assign sync.reset_fall = s3_reg[3] & ~s2_reg[3]; // Release edge
  assign sync.ack_fall = s3_reg[4] & ~s2_reg[4];
endmodule

// ===== rtl/sorl_pkg.sv
// Constants shared by the safety output release logic
// Assumes a 20 MHz core clock; all timing counts derive from it
package sorl_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // Indicator flash rate while waiting for release
  localparam int unsigned FLASH_HZ = 5;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  // Longest allowed skew between the two safety inputs switching off
  localparam int unsigned DISC_MS = 500;
  localparam int unsigned DISC_CYC = (CLK_HZ / 1000) * DISC_MS;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DIAG_REQ_OFS = 8'h08;
  // Control field positions
  localparam int unsigned CTRL_MANUAL_BIT = 0;
  localparam int unsigned CTRL_DISC_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Serial request bit that acknowledges a discrepancy fault
  localparam int unsigned REQ_DISC_ACK_BIT = 6;
  localparam logic [7:0] DIAG_REQ_RST = 8'h00;
  // Release states
  typedef enum logic [1:0]
  {
    ST_WAIT = 2'b00,
    ST_ARMED = 2'b01,
    ST_RELEASED = 2'b10,
    ST_FAULT = 2'b11
  } sorl_state_t;
endpackage

// ===== rtl/sorl_sync_if.sv
// Bundle of synchronised input levels and edges passed between modules
// Assumes all members are on the core clock
`timescale 1ns/1ps
interface sorl_sync_if;
  logic feedback;
  logic safe_a;
  logic safe_b;
  logic reset_fall;
  logic ack_fall;
  modport src (output feedback, safe_a, safe_b, reset_fall, ack_fall);
  modport dst (input feedback, safe_a, safe_b, reset_fall, ack_fall);
endinterface

// ===== rtl/sorl_top.sv
// Safety output release logic with APB control and discrepancy latch
// Assumes pins are asynchronous; the fault latch is backed by external
// non-volatile storage through the NV_* ports
`timescale 1ns/1ps
module sorl_top #(
  parameter int unsigned DISC_CYCLES = sorl_pkg::DISC_CYC,
  parameter int unsigned FLASH_CYCLES = sorl_pkg::FLASH_HALF_CYC
) (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic FEEDBACK_LOOP_IN,
  input wire logic SAFETY_INPUT_A_IN,
  input wire logic SAFETY_INPUT_B_IN,
  input wire logic RESET_BUTTON_IN,
  input wire logic ACK_BUTTON_IN,
  input wire logic NV_FAULT_IN,
  output logic NV_FAULT_OUT,
  output logic SAFETY_OUTPUT_A_OUT,
  output logic SAFETY_OUTPUT_B_OUT,
  output logic YELLOW_LED_OUT,
  output logic DISC_FAULT_OUT
);
  initial
  begin
    if (DISC_CYCLES < 1 || FLASH_CYCLES < 1)
      $error("sorl_top counts must be at least one");
  end
  localparam int FW = $clog2(FLASH_CYCLES + 1);

  sorl_sync_if sync ();
  logic disc_expired;
  logic nv_s1_reg, nv_s2_reg;

  sorl_in_sync #(.N(5)) u_sync (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .pins_in({ACK_BUTTON_IN, RESET_BUTTON_IN, SAFETY_INPUT_B_IN, SAFETY_INPUT_A_IN, FEEDBACK_LOOP_IN}),
    .sync(sync)
  );

  // Control registers and serial request byte
  logic [1:0] ctrl_reg, ctrl_next;
  logic [7:0] req_reg, req_next;
  logic [31:0] rdata_reg, rdata_next;
  logic manual_reset_variant, disc_en;
  assign manual_reset_variant = ctrl_reg[sorl_pkg::CTRL_MANUAL_BIT];
  assign disc_en = ctrl_reg[sorl_pkg::CTRL_DISC_EN_BIT];

  sorl_disc_timer #(.LIMIT(DISC_CYCLES)) u_disc (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .enable_in(disc_en),
    .safe_a_in(sync.safe_a),
    .safe_b_in(sync.safe_b),
    .expired_out(disc_expired)
  );

  // Writes happen on the APB access cycle, reads sample the registers in the setup cycle; zero wait states
  logic wr_en, rd_en;
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign PREADY_OUT = 1'b1;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == sorl_pkg::CTRL_OFS) || (a == sorl_pkg::STATUS_OFS) || (a == sorl_pkg::DIAG_REQ_OFS);
  endfunction

  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok(PADDR_IN);

  // Release state machine and fault latch
  sorl_pkg::sorl_state_t state_reg, state_next;
  logic fault_reg, fault_next;
  logic [1:0] nv_cnt_reg, nv_cnt_next;
  logic nv_loaded;
  logic [FW-1:0] flash_cnt_reg, flash_cnt_next;
  logic flash_reg, flash_next;
  logic serial_ack;
  logic ack_event;
  logic safe_ok;

  // Serial acknowledge is the falling edge of request bit 6
  assign serial_ack = wr_en && (PADDR_IN == sorl_pkg::DIAG_REQ_OFS)
    && req_reg[sorl_pkg::REQ_DISC_ACK_BIT] && !PWDATA_IN[sorl_pkg::REQ_DISC_ACK_BIT];
  assign ack_event = serial_ack | sync.ack_fall;
  assign safe_ok = sync.safe_a & sync.safe_b;
  // The stored level is trusted only once both sync stages hold post-reset samples
  assign nv_loaded = (nv_cnt_reg == 2'h3);

  // Bus registers next state
  always_comb
  begin
    ctrl_next = ctrl_reg;
    req_next = req_reg;
    rdata_next = rdata_reg;
    if (wr_en && (PADDR_IN == sorl_pkg::CTRL_OFS))
      ctrl_next = PWDATA_IN[1:0];
    if (wr_en && (PADDR_IN == sorl_pkg::DIAG_REQ_OFS))
      req_next = PWDATA_IN[7:0];
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
    begin
      case (PADDR_IN)
        sorl_pkg::CTRL_OFS: rdata_next = {30'h0, ctrl_reg};
        sorl_pkg::STATUS_OFS: rdata_next = {25'h0, sync.feedback, sync.safe_b, sync.safe_a,
                                            fault_reg, state_reg, (state_reg == sorl_pkg::ST_RELEASED)};
        sorl_pkg::DIAG_REQ_OFS: rdata_next = {24'h0, req_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      ctrl_reg <= sorl_pkg::CTRL_RST;
      req_reg <= sorl_pkg::DIAG_REQ_RST;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      req_reg <= req_next;
      rdata_reg <= rdata_next;
    end
  end
  assign PRDATA_OUT = rd_en ? rdata_reg : 32'h0;

  // Stored fault level is a pin from the storage device, so it is synchronised
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      nv_s1_reg <= 1'b0;
      nv_s2_reg <= 1'b0;
    end
    else
    begin
      nv_s1_reg <= NV_FAULT_IN;
      nv_s2_reg <= nv_s1_reg;
    end
  end

  // Release decision; a new discrepancy wins over an acknowledge in the same cycle
  always_comb
  begin
    state_next = state_reg;
    fault_next = fault_reg;
    nv_cnt_next = nv_loaded ? nv_cnt_reg : nv_cnt_reg + 2'h1;
    if (!nv_loaded)
    begin
      // Sync stages were cleared by reset, so the stored level loads on the third edge
      if (nv_cnt_reg == 2'h2)
        fault_next = nv_s2_reg; // Restore stored fault after power-up
    end
    else if (disc_expired)
      fault_next = 1'b1;
    else if (ack_event)
      fault_next = 1'b0;
    case (state_reg)
      sorl_pkg::ST_WAIT:
      begin
        if (fault_reg)
          state_next = sorl_pkg::ST_FAULT;
        else if (nv_loaded && sync.feedback && safe_ok)
        begin
          if (manual_reset_variant)
            state_next = sorl_pkg::ST_ARMED; // Loop alone does not release
          else
            state_next = sorl_pkg::ST_RELEASED; // Level only, no edge
        end
      end
      sorl_pkg::ST_ARMED:
      begin
        if (fault_reg || disc_expired)
          state_next = sorl_pkg::ST_FAULT;
        else if (!sync.feedback || !safe_ok || !manual_reset_variant)
          state_next = sorl_pkg::ST_WAIT;
        else if (sync.reset_fall)
          state_next = sorl_pkg::ST_RELEASED; // Switch on at button release
      end
      sorl_pkg::ST_RELEASED:
      begin
        if (disc_expired || fault_reg)
          state_next = sorl_pkg::ST_FAULT;
        else if (!safe_ok)
          state_next = sorl_pkg::ST_WAIT;
      end
      sorl_pkg::ST_FAULT:
      begin
        if (!fault_reg)
          state_next = sorl_pkg::ST_WAIT; // Blocked until acknowledged
      end
      default: state_next = sorl_pkg::ST_WAIT;
    endcase
    // Either safety input dropping while released returns to waiting
    if (state_reg == sorl_pkg::ST_RELEASED && state_next == sorl_pkg::ST_RELEASED && !safe_ok)
      state_next = sorl_pkg::ST_WAIT;
  end

  // Flash divider for the yellow indicator while waiting
  always_comb
  begin
    flash_cnt_next = flash_cnt_reg + FW'(1);
    flash_next = flash_reg;
    if (flash_cnt_reg >= FW'(FLASH_CYCLES - 1))
    begin
      flash_cnt_next = '0;
      flash_next = ~flash_reg;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state_reg <= sorl_pkg::ST_WAIT;
      fault_reg <= 1'b0;
      nv_cnt_reg <= 2'h0;
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      nv_cnt_reg <= nv_cnt_next;
      flash_cnt_reg <= flash_cnt_next;
      flash_reg <= flash_next;
    end
  end

  // Outputs decoded from registered state; no glitch path from pins
  logic released;
  assign released = (state_reg == sorl_pkg::ST_RELEASED);
  assign SAFETY_OUTPUT_A_OUT = released;
  assign SAFETY_OUTPUT_B_OUT = released;
  assign YELLOW_LED_OUT = released | ((state_reg != sorl_pkg::ST_FAULT) & flash_reg);
  assign DISC_FAULT_OUT = fault_reg;
  assign NV_FAULT_OUT = fault_reg; // Written through to storage
endmodule

// ===== test/sorl_relay_model.sv
// Two output relays whose normally closed contacts form the feedback loop
// Assumes coils follow the safety outputs after dly_in + 1 clocks
`timescale 1ns/1ps
module sorl_relay_model (
  input wire logic clk_in,
  input wire logic drv_a_in,
  input wire logic drv_b_in,
  input wire logic open_in,
  input wire logic [3:0] dly_in,
  output logic loop_out
);
  logic [15:0] ka = '0;
  logic [15:0] kb = '0;
  // Contact lag; a slow relay keeps the loop open longer after drop-out
  always @(posedge clk_in)
  begin
    ka <= {ka[14:0], drv_a_in};
    kb <= {kb[14:0], drv_b_in};
  end
  // Loop closed only with both relays dropped and the loop button pressed
  assign loop_out = !open_in && !ka[dly_in] && !kb[dly_in];
endmodule

// ===== test/sorl_top_sva.sv
// Port checker for the safety output release logic
// Bound to sorl_top; sees its ports only, names match one to one
`timescale 1ns/1ps
module sorl_top_sva (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic FEEDBACK_LOOP_IN,
  input wire logic SAFETY_INPUT_A_IN,
  input wire logic SAFETY_INPUT_B_IN,
  input wire logic RESET_BUTTON_IN,
  input wire logic ACK_BUTTON_IN,
  input wire logic NV_FAULT_OUT,
  input wire logic SAFETY_OUTPUT_A_OUT,
  input wire logic SAFETY_OUTPUT_B_OUT,
  input wire logic YELLOW_LED_OUT,
  input wire logic DISC_FAULT_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic [7:0] fb_h, rb_h, ak_h, dq_h;
  logic rb_q, ak_q, man_q, wr;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  // Cause histories; the sync path puts a few cycles between cause and effect
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      {fb_h, rb_h, ak_h, dq_h, rb_q, ak_q, man_q} <= '0;
    else
    begin
      fb_h <= {fb_h[6:0], FEEDBACK_LOOP_IN};
      rb_h <= {rb_h[6:0], rb_q && !RESET_BUTTON_IN};
      ak_h <= {ak_h[6:0], ak_q && !ACK_BUTTON_IN};
      dq_h <= {dq_h[6:0], wr && PADDR_IN == sorl_pkg::DIAG_REQ_OFS && !PWDATA_IN[6]};
      rb_q <= RESET_BUTTON_IN;
      ak_q <= ACK_BUTTON_IN;
      if (wr && PADDR_IN == sorl_pkg::CTRL_OFS)
        man_q <= PWDATA_IN[0];
    end
  end
  a_outs_paired: assert property (SAFETY_OUTPUT_A_OUT == SAFETY_OUTPUT_B_OUT)
    else $error("safety outputs differ");
  a_rise_needs_loop: assert property ($rose(SAFETY_OUTPUT_A_OUT) |-> fb_h != 8'h00)
    else $error("release without closed loop");
  a_manual_on_release: assert property ($rose(SAFETY_OUTPUT_A_OUT) && man_q |-> rb_h != 8'h00)
    else $error("manual release without button release");
  a_fault_blocks_out: assert property (DISC_FAULT_OUT [*3] |-> !SAFETY_OUTPUT_A_OUT && !YELLOW_LED_OUT)
    else $error("outputs on during fault");
  a_led_steady_on: assert property (SAFETY_OUTPUT_A_OUT [*2] |-> YELLOW_LED_OUT)
    else $error("indicator not steady while released");
  a_clear_has_cause: assert property ($fell(DISC_FAULT_OUT) |-> (ak_h | dq_h) != 8'h00)
    else $error("fault cleared without acknowledge");
  a_nv_keeps_fault: assert property ($rose(DISC_FAULT_OUT) |-> ##[0:1] NV_FAULT_OUT)
    else $error("fault not passed to storage");
  a_inputs_off_drop: assert property ((!SAFETY_INPUT_A_IN || !SAFETY_INPUT_B_IN) [*6] |-> !SAFETY_OUTPUT_A_OUT)
    else $error("outputs on with safety input off");
  c_auto_release: cover property ($rose(SAFETY_OUTPUT_A_OUT) && !man_q);
  c_manual_release: cover property ($rose(SAFETY_OUTPUT_A_OUT) && man_q);
  c_fault_set: cover property ($rose(DISC_FAULT_OUT));
  c_fault_clear: cover property ($fell(DISC_FAULT_OUT));
endmodule
bind sorl_top sorl_top_sva i_sorl_top_sva (.*);

// ===== test/tb.sv
// Self-checking bench for the safety output release logic
// Assumes the relay model closes the loop; storage follows the fault output
`timescale 1ns/1ps
module tb;
  localparam int DC = 20;
  localparam int FC = 4;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, fb, oa, ob, led, flt, nvo, q;
  logic sa = 1'b1, sb = 1'b1, rb = 1'b0, ak = 1'b0, nvi = 1'b0, opn = 1'b1;
  logic [3:0] dly = 4'h3;
  logic [2:0] rq = 3'h0;
  int n_fail = 0, n_compared = 0, seed = 89429, i, e, skew;
  sorl_top #(.DISC_CYCLES(DC), .FLASH_CYCLES(FC)) i_sorl_top (.MCLK_IN(clk), .ARST_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FEEDBACK_LOOP_IN(fb),
    .SAFETY_INPUT_A_IN(sa), .SAFETY_INPUT_B_IN(sb), .RESET_BUTTON_IN(rb), .ACK_BUTTON_IN(ak),
    .NV_FAULT_IN(nvi), .NV_FAULT_OUT(nvo), .SAFETY_OUTPUT_A_OUT(oa), .SAFETY_OUTPUT_B_OUT(ob),
    .YELLOW_LED_OUT(led), .DISC_FAULT_OUT(flt));
  sorl_relay_model i_sorl_relay_model (.clk_in(clk), .drv_a_in(oa), .drv_b_in(ob), .open_in(opn),
    .dly_in(dly), .loop_out(fb));
  initial
    forever #25 clk = ~clk;
  // Storage keeps the fault while power is off; it only learns once reset settles
  always @(posedge clk)
  begin
    rq <= {rq[1:0], rst_n};
    if (rq[2] && rst_n)
      nvi <= nvo;
  end
  function automatic logic fault_exp(input int s);
    return s > DC;
  endfunction
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; an idle edge first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Wait for the outputs (f=0) or the fault flag (f=1) to reach v
  task automatic wt(input logic v, input logic f);
    int k;
    for (k = 0; k < 60 && (f ? flt : oa) !== v; k++)
      @(posedge clk);
    if (k >= 60)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic push_reset();
    rb <= 1'b1;
    cyc(4);
    rb <= 1'b0;
  endtask
  initial
  begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(8);
    e = 0;
    q = led;
    repeat (24)
    begin
      @(posedge clk);
      e += (led !== q);
      q = led;
    end
    chk("led toggles", e, 24 / FC);
    chk("outputs", {ob, oa}, 0);
    apb(1'b0, sorl_pkg::STATUS_OFS, 0);
    chk("status", rd, 32'h30);
    apb(1'b0, sorl_pkg::CTRL_OFS, 0);
    chk("ctrl reset", rd, 0);
    apb(1'b0, 8'h0c, 0);
    chk("unmapped err", err, 1);
    chk("unmapped rd", rd, 0);
    e = $random(seed) & 8'hbf;
    apb(1'b1, sorl_pkg::DIAG_REQ_OFS, e);
    apb(1'b0, sorl_pkg::DIAG_REQ_OFS, 0);
    chk("diag req", rd, e);
    opn <= 1'b0;
    wt(1'b1, 1'b0);
    chk("auto led", led, 1);
    sa <= 1'b0;
    sb <= 1'b0;
    wt(1'b0, 1'b0);
    apb(1'b1, sorl_pkg::CTRL_OFS, 1);
    sa <= 1'b1;
    sb <= 1'b1;
    cyc(20);
    chk("loop only", oa, 0);
    rb <= 1'b1;
    cyc(10);
    chk("on press", oa, 0);
    rb <= 1'b0;
    wt(1'b1, 1'b0);
    chk("on release", {ob, oa}, 3);
    // Check disabled: a long skew must not latch a fault
    sa <= 1'b0;
    cyc(DC + 5);
    sb <= 1'b0;
    cyc(5);
    chk("disc off", flt, 0);
    wt(1'b0, 1'b0);
    opn <= 1'b1;
    sa <= 1'b1;
    sb <= 1'b1;
    push_reset();
    cyc(10);
    chk("loop open", oa, 0);
    opn <= 1'b0;
    apb(1'b1, sorl_pkg::CTRL_OFS, 3);
    // Random skews around the limit, with both ways to acknowledge
    for (i = 0; i < 8; i++)
    begin
      dly <= 4'(i + 1);
      e = (i < 4) ? i % 2 : $random(seed) & 1;
      // Skews of exactly the limit and one above are the corners
      skew = (i == 2) ? DC : (i == 3) ? DC + 1 : ($random(seed) & 15) + (e ? DC + 5 : 0);
      push_reset();
      wt(1'b1, 1'b0);
      sa <= 1'b0;
      cyc(skew);
      sb <= 1'b0;
      cyc(10);
      chk("fault", flt, fault_exp(skew));
      sa <= 1'b1;
      sb <= 1'b1;
      if (flt === 1'b1)
      begin
        chk("nv out", nvo, 1);
        cyc(10);
        push_reset();
        cyc(10);
        chk("blocked", oa, 0);
        if (i[1])
        begin
          ak <= 1'b1;
          cyc(5);
          chk("ack press", flt, 1);
          ak <= 1'b0;
        end
        else
        begin
          apb(1'b1, sorl_pkg::DIAG_REQ_OFS, 32'h40);
          cyc(5);
          chk("ack rise", flt, 1);
          apb(1'b1, sorl_pkg::DIAG_REQ_OFS, 0);
        end
        wt(1'b0, 1'b1);
      end
      cyc(10);
    end
    sa <= 1'b0;
    cyc(DC + 10);
    sa <= 1'b1;
    cyc(10);
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(6);
    chk("fault kept", {oa, flt}, 1);
    ak <= 1'b1;
    cyc(3);
    ak <= 1'b0;
    wt(1'b0, 1'b1);
    chk("ack clear", flt, 0);
    report_and_stop();
  end
endmodule
